// >>> sdasp_pkg.sv
// constants of the stereo serial audio receive port: register indices, field places,
// reset values, format and word-length codes.
// assumes a 32-bit classic wishbone slave with one register per aligned word.
package sdasp_pkg;
   // register indices; the byte address is four times the index
   localparam logic [7:0] IDX_IFACE  = 8'h1B;   // format, width, clock directions
   localparam logic [7:0] IDX_OFFSET = 8'h1C;   // data offset in bit clocks
   localparam logic [7:0] IDX_CLKCTL = 8'h1D;   // bit-clock inversion, keep running
   localparam logic [7:0] IDX_BDIV   = 8'h1E;   // bit-clock divider
   localparam logic [7:0] IDX_SEL    = 8'h20;   // primary / secondary select
   localparam logic [7:0] IDX_ROUTE  = 8'h21;   // output clock sources
   localparam logic [7:0] IDX_FRAME  = 8'h22;   // bit clocks per generated frame
   localparam logic [7:0] IDX_POWER  = 8'h23;   // converter power
   localparam logic [7:0] IDX_STATUS = 8'h24;   // frame count and running flag
   localparam logic [7:0] IDX_LEFT   = 8'h25;   // last left sample
   localparam logic [7:0] IDX_RIGHT  = 8'h26;   // last right sample
   localparam int ADR_LSB = 2;
   // field positions
   localparam int F_FMT_LO   = 6;
   localparam int F_WLEN_LO  = 4;
   localparam int F_BCLK_DIR = 3;
   localparam int F_WCLK_DIR = 2;
   localparam int F_PULSE    = 0;
   localparam int F_INV      = 3;
   localparam int F_KEEP     = 2;
   localparam int F_BDIV_EN  = 7;
   localparam int F_DIN_SEL  = 0;
   localparam int F_WSRC_LO  = 4;
   localparam int F_BSRC     = 7;
   localparam int F_PWR      = 0;
   // reset values
   localparam logic [7:0] RST_IFACE  = 8'h00;
   localparam logic [7:0] RST_OFFSET = 8'h00;
   localparam logic [7:0] RST_CLKCTL = 8'h00;
   localparam logic [7:0] RST_BDIV   = 8'h01;
   localparam logic [7:0] RST_SEL    = 8'h00;
   localparam logic [7:0] RST_ROUTE  = 8'h00;
   localparam logic [7:0] RST_FRAME  = 8'h40;
   localparam logic [7:0] RST_POWER  = 8'h00;
   // frame formats
   typedef enum logic [1:0] {
      FMT_I2S = 2'b00,
      FMT_DSP = 2'b01,
      FMT_RJ  = 2'b10,
      FMT_LJ  = 2'b11
   } sdasp_fmt_t;
   // word-length codes and widths
   localparam logic [5:0] WLEN_16 = 6'h10;
   localparam logic [5:0] WLEN_20 = 6'h14;
   localparam logic [5:0] WLEN_24 = 6'h18;
   localparam logic [5:0] WLEN_32 = 6'h20;
   // secondary word clock as primary word clock source
   localparam logic [1:0] WSRC_SEC = 2'b01;
endpackage

// >>> sdasp_sync.sv
// two-stage synchroniser for a group of pin levels.
// assumes the inputs are asynchronous to clk_i.
`timescale 1ns/100ps
module sdasp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule // sdasp_sync

// >>> sdasp_top.sv
// stereo serial audio receive port with clock generation and a wishbone register file.
// assumes a single 25 MHz clock; all serial pins are asynchronous and are synchronised.
//
// Functional notes
// - two-bit width field picks 16, 20, 24 or 32 bit samples.
// - samples travel most significant bit first in every format.
// - word clock and bit clock directions are set separately.
// - word clock marks frame start, pulse or square, at sample rate.
// - generated bit clock pulse count per frame follows the frame register.
// - first data bit is delayed by a programmable number of bit clocks, except in right-justified format.
// - one control bit inverts the receiver's bit-clock polarity in every format.
// - generated clocks run only while powered, unless kept running.
// - right-justified: LSB on last rising edge before word-clock edge.
// - left-justified: MSB on first rising edge after word-clock edge.
// - I2S: MSB on second rising edge after word-clock edge.
// - DSP: word-clock fall starts left then right, falling-edge data.
// - primary or secondary interface, one at a time, by configuration.
// - driven word clock comes from sample rate or secondary word clock.
// - with direction bit clear the word clock pin is an input.
// - bit-clock divider is seven bits, ratios 1 to 128.
// - select bit routes primary or secondary data to the receiver.
`timescale 1ns/100ps
module sdasp_top (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // primary serial pins
   input  wire logic        bclk_i,
   output logic             bclk_o,
   output logic             bclk_oe_o,
   input  wire logic        wclk_i,
   output logic             wclk_o,
   output logic             wclk_oe_o,
   input  wire logic        din_i,
   // secondary serial inputs
   input  wire logic        sec_bclk_i,
   input  wire logic        sec_wclk_i,
   input  wire logic        sec_din_i,
   // received samples
   output logic      [31:0] left_o,
   output logic      [31:0] right_o,
   output logic             sample_valid_o
);
   ////////////////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]  reg_iface;
   logic [7:0]  reg_offset;
   logic [7:0]  reg_clkctl;
   logic [7:0]  reg_bdiv;
   logic [7:0]  reg_sel;
   logic [7:0]  reg_route;
   logic [7:0]  reg_frame;
   logic [7:0]  reg_power;
   logic [15:0] frame_cnt;
   logic [7:0]  idx;
   logic        wr_now;
   logic [31:0] next_dat;
   logic        run;

   localparam int ADR_LSB_W = sdasp_pkg::ADR_LSB;
   assign idx    = {2'b00, adr_i[7:ADR_LSB_W]};
   // the write lands on the edge where the master sees ack
   assign wr_now = cyc_i & stb_i & we_i & ack_o & sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i & stb_i & ~ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reg_iface  <= sdasp_pkg::RST_IFACE;
         reg_offset <= sdasp_pkg::RST_OFFSET;
         reg_clkctl <= sdasp_pkg::RST_CLKCTL;
         reg_bdiv   <= sdasp_pkg::RST_BDIV;
         reg_sel    <= sdasp_pkg::RST_SEL;
         reg_route  <= sdasp_pkg::RST_ROUTE;
         reg_frame  <= sdasp_pkg::RST_FRAME;
         reg_power  <= sdasp_pkg::RST_POWER;
      end else if (wr_now) begin
         case (idx)
            sdasp_pkg::IDX_IFACE:  reg_iface  <= dat_i[7:0];
            sdasp_pkg::IDX_OFFSET: reg_offset <= dat_i[7:0];
            sdasp_pkg::IDX_CLKCTL: reg_clkctl <= dat_i[7:0];
            sdasp_pkg::IDX_BDIV:   reg_bdiv   <= dat_i[7:0];
            sdasp_pkg::IDX_SEL:    reg_sel    <= dat_i[7:0];
            sdasp_pkg::IDX_ROUTE:  reg_route  <= dat_i[7:0];
            sdasp_pkg::IDX_FRAME:  reg_frame  <= dat_i[7:0];
            sdasp_pkg::IDX_POWER:  reg_power  <= dat_i[7:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      next_dat = '0;
      case (idx)
         sdasp_pkg::IDX_IFACE:  next_dat[7:0] = reg_iface;
         sdasp_pkg::IDX_OFFSET: next_dat[7:0] = reg_offset;
         sdasp_pkg::IDX_CLKCTL: next_dat[7:0] = reg_clkctl;
         sdasp_pkg::IDX_BDIV:   next_dat[7:0] = reg_bdiv;
         sdasp_pkg::IDX_SEL:    next_dat[7:0] = reg_sel;
         sdasp_pkg::IDX_ROUTE:  next_dat[7:0] = reg_route;
         sdasp_pkg::IDX_FRAME:  next_dat[7:0] = reg_frame;
         sdasp_pkg::IDX_POWER:  next_dat[7:0] = reg_power;
         sdasp_pkg::IDX_STATUS: next_dat = {frame_cnt, 15'h0000, run};
         sdasp_pkg::IDX_LEFT:   next_dat = left_o;
         sdasp_pkg::IDX_RIGHT:  next_dat = right_o;
         default:               next_dat = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (cyc_i & stb_i & ~ack_o) begin
         dat_o <= next_dat;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // field decode
   sdasp_pkg::sdasp_fmt_t fmt;
   logic [5:0]  wlen;
   logic        bclk_inv;
   logic        din_sel;

   assign fmt      = sdasp_pkg::sdasp_fmt_t'(reg_iface[sdasp_pkg::F_FMT_LO +: 2]);
   assign bclk_inv = reg_clkctl[sdasp_pkg::F_INV];
   assign din_sel  = reg_sel[sdasp_pkg::F_DIN_SEL];
   // clocks stop with the converter unless kept running
   assign run = reg_bdiv[sdasp_pkg::F_BDIV_EN] &
                (reg_power[sdasp_pkg::F_PWR] | reg_clkctl[sdasp_pkg::F_KEEP]);

   always_comb begin
      case (reg_iface[sdasp_pkg::F_WLEN_LO +: 2])
         2'b00:   wlen = sdasp_pkg::WLEN_16;
         2'b01:   wlen = sdasp_pkg::WLEN_20;
         2'b10:   wlen = sdasp_pkg::WLEN_24;
         default: wlen = sdasp_pkg::WLEN_32;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [5:0] pins_s;
   logic       p_bclk;
   logic       p_wclk;
   logic       p_din;
   logic       s_bclk;
   logic       s_wclk;
   logic       s_din;

   sdasp_sync #(.WIDTH(6)) u_sync (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .async_i({sec_din_i, sec_wclk_i, sec_bclk_i, din_i, wclk_i, bclk_i}),
      .sync_o (pins_s)
   );
   assign {s_din, s_wclk, s_bclk, p_din, p_wclk, p_bclk} = pins_s;

   ////////////////////////////////////////////////////////////////////////////////////////
   // clock generation: the bit clock toggles every divider count, so one bit clock
   // period is twice the ratio in system clocks; a 25 MHz clock needs no finer step
   logic [6:0] div_cnt;
   logic       bclk_int;
   logic [7:0] fcnt;
   logic       wclk_int;
   logic [8:0] frame_len;
   logic [8:0] half_len_gen;
   logic       bclk_fall;

   assign frame_len    = (reg_frame == 8'h00) ? 9'h100 : {1'b0, reg_frame};
   assign half_len_gen = frame_len >> 1;
   assign bclk_fall    = bclk_int & (div_cnt == (reg_bdiv[6:0] - 7'h01));

   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         div_cnt  <= '0;
         bclk_int <= 1'b0;
      end else if (div_cnt == (reg_bdiv[6:0] - 7'h01)) begin
         div_cnt  <= '0;
         bclk_int <= ~bclk_int;
      end else begin
         div_cnt <= div_cnt + 7'h01;
      end
   end

   // frame counter advances on each generated bit-clock fall
   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         fcnt <= '0;
      end else if (bclk_fall) begin
         fcnt <= ({1'b0, fcnt} == frame_len - 9'h001) ? 8'h00 : fcnt + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         wclk_int <= 1'b0;
      end else if (reg_iface[sdasp_pkg::F_PULSE]) begin
         wclk_int <= (fcnt == 8'h00);
      end else begin
         wclk_int <= ({1'b0, fcnt} < half_len_gen);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bclk_o    <= 1'b0;
         bclk_oe_o <= 1'b0;
         wclk_o    <= 1'b0;
         wclk_oe_o <= 1'b0;
      end else begin
         bclk_o    <= reg_route[sdasp_pkg::F_BSRC] ? s_bclk : bclk_int;
         bclk_oe_o <= reg_iface[sdasp_pkg::F_BCLK_DIR];
         wclk_o    <= (reg_route[sdasp_pkg::F_WSRC_LO +: 2] == sdasp_pkg::WSRC_SEC) ?
                      s_wclk : wclk_int;
         wclk_oe_o <= reg_iface[sdasp_pkg::F_WCLK_DIR];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // receiver: the driven pins read back through the pad, so master and slave
   // share one path
   logic       r_bclk;
   logic       r_wclk;
   logic       r_din;
   logic       bclk_eff;
   logic       bclk_prev;
   logic       cap;
   logic       wclk_prev;
   logic       restart;
   logic [8:0] bcnt;
   logic [8:0] half_len;
   logic [9:0] pos;
   logic [9:0] start;
   logic [9:0] k;
   logic       right_ch;
   logic       in_word;
   logic       last_bit;
   logic [31:0] shreg;
   logic [31:0] next_shreg;

   assign r_bclk   = din_sel ? s_bclk : p_bclk;
   assign r_wclk   = din_sel ? s_wclk : p_wclk;
   assign r_din    = din_sel ? s_din  : p_din;
   // dsp captures on the falling edge, hence one more inversion
   assign bclk_eff = r_bclk ^ bclk_inv ^ (fmt == sdasp_pkg::FMT_DSP);
   assign cap      = bclk_eff & ~bclk_prev;
   assign restart  = (fmt == sdasp_pkg::FMT_DSP) ? (wclk_prev & ~r_wclk)
                                                 : (wclk_prev ^ r_wclk);
   assign pos      = restart ? 10'h000 : {1'b0, bcnt} + 10'h001;

   always_comb begin
      start    = {2'b00, reg_offset};
      right_ch = ~r_wclk;
      case (fmt)
         sdasp_pkg::FMT_I2S: begin
            start    = {2'b00, reg_offset} + 10'h001;
            right_ch = r_wclk;
         end
         sdasp_pkg::FMT_LJ: begin
            start    = {2'b00, reg_offset};
         end
         sdasp_pkg::FMT_RJ: begin
            start    = {1'b0, half_len} - {4'h0, wlen};
         end
         sdasp_pkg::FMT_DSP: begin
            right_ch = (pos >= {2'b00, reg_offset} + {4'h0, wlen});
            start    = {2'b00, reg_offset} + (right_ch ? {4'h0, wlen} : 10'h000);
         end
         default: ;
      endcase
   end

   assign k          = pos - start;
   assign in_word    = (pos >= start) && (k < {4'h0, wlen});
   assign last_bit   = in_word && (k == {4'h0, wlen} - 10'h001);
   assign next_shreg = {shreg[30:0], r_din};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bclk_prev <= 1'b0;
         wclk_prev <= 1'b0;
      end else begin
         bclk_prev <= bclk_eff;
         if (cap) begin
            wclk_prev <= r_wclk;
         end
      end
   end

   // the last half length sets where a right-justified word must start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bcnt     <= '0;
         half_len <= '0;
      end else if (cap) begin
         if (restart) begin
            half_len <= bcnt + 9'h001;
            bcnt     <= '0;
         end else if (bcnt != 9'h1FF) begin
            bcnt <= bcnt + 9'h001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shreg <= '0;
      end else if (cap && in_word) begin
         shreg <= (k == 10'h000) ? {31'h00000000, r_din} : next_shreg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         left_o         <= '0;
         right_o        <= '0;
         sample_valid_o <= 1'b0;
         frame_cnt      <= '0;
      end else begin
         sample_valid_o <= 1'b0;
         if (cap && last_bit) begin
            if (right_ch) begin
               right_o        <= next_shreg;
               sample_valid_o <= 1'b1;
               frame_cnt      <= frame_cnt + 16'h0001;
            end else begin
               left_o <= next_shreg;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence

   chk_ack_timing: assert property (s_req |=> ack_o ##1 !ack_o)
      else $error("ack not one cycle after request");
   chk_bclk_dir: assert property (##1 bclk_oe_o == $past(reg_iface[sdasp_pkg::F_BCLK_DIR]))
      else $error("bit clock enable does not follow direction");
   chk_wclk_dir: assert property (##1 wclk_oe_o == $past(reg_iface[sdasp_pkg::F_WCLK_DIR]))
      else $error("word clock enable does not follow direction");
   chk_clk_stop: assert property (!run |=> !bclk_int && fcnt == 8'h00)
      else $error("generated clock runs while stopped");
   chk_div_hold: assert property ($rose(bclk_int) && reg_bdiv[6:0] == 7'h03 && $stable(reg_bdiv)
                                  |-> bclk_int [*3] ##1 !bclk_int)
      else $error("bit clock half period wrong");
   chk_wsrc_sec: assert property (reg_route[sdasp_pkg::F_WSRC_LO +: 2] == sdasp_pkg::WSRC_SEC
                                  |=> wclk_o == $past(s_wclk))
      else $error("word clock not from secondary");
   chk_valid_pulse: assert property (sample_valid_o |=> !sample_valid_o)
      else $error("sample valid longer than one cycle");
   chk_msb_first: assert property (cap && last_bit && right_ch |=> right_o[0] == $past(r_din))
      else $error("last bit received is not the lsb");
   chk_restart_pos: assert property (cap && restart |=> bcnt == 9'h000)
      else $error("bit counter not cleared at frame edge");
endmodule // sdasp_top

// >>> sdasp_host_model.sv
// behavioural host processor that clocks stereo frames into the receive port.
// assumes it owns both clocks; they stand still between frames.
`timescale 1ns/100ps
module sdasp_host_model (
   // clock
   input  wire logic clk_i,
   // serial pins
   output logic      bclk_o,
   output logic      wclk_o,
   output logic      din_o
);
   initial begin
      bclk_o = 1'b1;
      wclk_o = 1'b1;
      din_o  = 1'b0;
   end
   task automatic half();
      repeat (4) @(posedge clk_i);
   endtask
   // one frame of 2*h bit clocks; samples come already cut to w bits
   task automatic frame(input logic [1:0] fmt, input int w, input int off, input logic inv,
                        input int h, input logic [31:0] l, input logic [31:0] r);
      logic [63:0] c;
      int          n;
      int          b;
      int          lim;
      logic        dsp;
      dsp = (fmt == 2'b01);
      for (n = 0; n < 2 * h; n++) begin
         c   = dsp ? (({32'h0, l} << w) | {32'h0, r}) : {32'h0, (n < h) ? l : r};
         lim = dsp ? 2 * w : w;
         case (fmt)
            2'b00:   b = w + off - n % h;
            2'b11:   b = w - 1 + off - n % h;
            2'b10:   b = h - 1 - n % h;
            default: b = 2 * w - 1 + off - n;
         endcase
         bclk_o <= dsp ^ inv;
         wclk_o <= dsp ? (n == 2 * h - 1) : ((fmt == 2'b00) == (n >= h));
         // released slots toggle so a stale level never looks like data
         din_o  <= (b >= 0 && b < lim) ? c[b] : ~din_o;
         half();
         bclk_o <= ~dsp ^ inv;
         half();
      end
   endtask
endmodule // sdasp_host_model

// >>> tb_sdasp_top.sv
// self-checking bench: registers, slave frames in every format and width, select, master clocks.
// assumes the design carries its own assertions.
`timescale 1ns/100ps
module tb_sdasp_top;
   logic        clk, rst, cyc, stb, we, ack, valid;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat_w, dat_r, left, right, got_l, got_r, l, r, m, x, q;
   logic        bclk_d, bclk_oe, wclk_d, wclk_oe, p_bclk, p_wclk, p_din, s_bclk, s_wclk, s_din;
   logic [1:0]  f, wc;
   logic        inv, s, v;
   int          vcnt, errors, num_checks, seed, k, j, w, off;
   wire         bclk_pin = bclk_oe ? bclk_d : p_bclk;
   wire         wclk_pin = wclk_oe ? wclk_d : p_wclk;

   sdasp_top dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .bclk_i(bclk_pin),
      .bclk_o(bclk_d), .bclk_oe_o(bclk_oe), .wclk_i(wclk_pin), .wclk_o(wclk_d),
      .wclk_oe_o(wclk_oe), .din_i(p_din), .sec_bclk_i(s_bclk), .sec_wclk_i(s_wclk),
      .sec_din_i(s_din), .left_o(left), .right_o(right), .sample_valid_o(valid));
   sdasp_host_model prim (.clk_i(clk), .bclk_o(p_bclk), .wclk_o(p_wclk), .din_o(p_din));
   sdasp_host_model sec (.clk_i(clk), .bclk_o(s_bclk), .wclk_o(s_wclk), .din_o(s_din));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (valid === 1'b1) begin
         got_l <= left;
         got_r <= right;
         vcnt  <= vcnt + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                     input logic [3:0] be);
      int i;
      @(posedge clk);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= wr;
      adr   <= {idx[5:0], 2'b00};
      sel   <= be;
      dat_w <= d;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (ack !== 1'b1 && i < 20);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i >= 20) begin
         errors++;
         stop_test();
      end
   endtask
   task automatic wrr(input logic [7:0] idx, input logic [31:0] d);
      wb(1'b1, idx, d, 4'hF);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 32'h0, 4'hF);
      check(q, exp);
   endtask
   // clock cycles between two changes of the chosen driven clock
   task automatic gap(input logic ws, input int exp);
      int i;
      int n;
      v = ws ? wclk_d : bclk_d;
      for (i = 0; i < 600 && v === (ws ? wclk_d : bclk_d); i++) @(posedge clk);
      v = ws ? wclk_d : bclk_d;
      n = 0;
      while (n < 600 && v === (ws ? wclk_d : bclk_d)) begin
         @(posedge clk);
         n++;
      end
      if (i >= 600 || n >= 600) begin
         errors++;
         stop_test();
      end
      check(n, exp);
   endtask
   function automatic int wbits(input logic [1:0] c);
      case (c)
         2'b00:   return int'(sdasp_pkg::WLEN_16);
         2'b01:   return int'(sdasp_pkg::WLEN_20);
         2'b10:   return int'(sdasp_pkg::WLEN_24);
         default: return int'(sdasp_pkg::WLEN_32);
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      {cyc, stb, we, adr, sel, dat_w, vcnt, errors, num_checks} = '0;
      seed = 32'h32CA17E6;
      rst  = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      check({30'h0, bclk_oe, wclk_oe}, 32'h0);
      rd(sdasp_pkg::IDX_BDIV, 32'h01);
      rd(sdasp_pkg::IDX_FRAME, 32'h40);
      wb(1'b1, sdasp_pkg::IDX_IFACE, 32'hFF, 4'hE);
      rd(sdasp_pkg::IDX_IFACE, 32'h0);
      wrr(8'h3F, 32'hA5);
      rd(8'h3F, 32'h0);
      // slave frames; the unselected host sends other data at the same time
      for (k = 0; k < 20; k++) begin
         f   = k[1:0];
         wc  = k[3:2];
         inv = (k >= 16);
         s   = (k >= 18);
         w   = wbits(wc);
         m   = (w == 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 1);
         off = (f == 2'b10) ? 0 : ($random(seed) & 1);
         l   = $random(seed) & m;
         r   = $random(seed) & m;
         wrr(sdasp_pkg::IDX_IFACE, {24'h0, f, wc, 4'h0});
         wrr(sdasp_pkg::IDX_OFFSET, off);
         wrr(sdasp_pkg::IDX_CLKCTL, {28'h0, inv, 3'b000});
         wrr(sdasp_pkg::IDX_SEL, {31'h0, s});
         for (j = 0; j < 2; j++) begin
            x = j ? 32'h0 : m;
            repeat (16) @(posedge clk);
            vcnt = 0;
            // 34 bit clocks per half leave room for 32 bits plus offset
            fork
               prim.frame(f, w, off, inv, 34, (l ^ x ^ (s ? 32'h5A5A5A5A : 32'h0)) & m,
                          (r ^ x ^ (s ? 32'h5A5A5A5A : 32'h0)) & m);
               sec.frame(f, w, off, inv, 34, (l ^ x ^ (s ? 32'h0 : 32'h5A5A5A5A)) & m,
                         (r ^ x ^ (s ? 32'h0 : 32'h5A5A5A5A)) & m);
            join
         end
         repeat (24) @(posedge clk);
         check(got_l, l);
         check(got_r, r);
         check(vcnt, 32'h1);
      end
      // generated clocks
      wrr(sdasp_pkg::IDX_SEL, 32'h0);
      wrr(sdasp_pkg::IDX_BDIV, 32'h83);
      wrr(sdasp_pkg::IDX_FRAME, 32'h08);
      wrr(sdasp_pkg::IDX_IFACE, 32'h0C);
      repeat (10) @(posedge clk);
      check({30'h0, bclk_oe, wclk_oe}, 32'h3);
      v = bclk_d;
      repeat (20) @(posedge clk);
      check({31'h0, bclk_d}, {31'h0, v});
      wrr(sdasp_pkg::IDX_POWER, 32'h1);
      gap(1'b0, 3);
      gap(1'b1, 24);
      wrr(sdasp_pkg::IDX_BDIV, 32'h80);
      gap(1'b0, 128);
      wrr(sdasp_pkg::IDX_POWER, 32'h0);
      wrr(sdasp_pkg::IDX_CLKCTL, 32'h4);
      wrr(sdasp_pkg::IDX_BDIV, 32'h83);
      gap(1'b0, 3);
      // pulse word clock: high one bit clock, low for the other seven
      wrr(sdasp_pkg::IDX_IFACE, 32'h0D);
      for (j = 0; j < 600 && wclk_d !== 1'b0; j++) @(posedge clk);
      for (j = 0; j < 600 && wclk_d !== 1'b1; j++) @(posedge clk);
      if (j >= 600) begin
         errors++;
         stop_test();
      end
      gap(1'b1, 42);
      wrr(sdasp_pkg::IDX_ROUTE, {24'h0, 2'b10, sdasp_pkg::WSRC_SEC, 4'h0});
      repeat (8) @(posedge clk);
      // both clocks toggle when internal, so a held match proves the secondary source
      for (j = 0; j < 50; j++) begin
         @(posedge clk);
         check({30'h0, wclk_d, bclk_d}, {30'h0, s_wclk, s_bclk});
      end
      wrr(sdasp_pkg::IDX_IFACE, 32'h0);
      repeat (4) @(posedge clk);
      check({30'h0, bclk_oe, wclk_oe}, 32'h0);
      stop_test();
   end
endmodule // tb_sdasp_top
